// ### hdl/adc_serial_frame_map.vh
// constants for the serial frame interface of the sampling converter
// assumes inclusion by the interface design file only
`ifndef ADC_SERIAL_FRAME_MAP_VH
`define ADC_SERIAL_FRAME_MAP_VH
`define FRAME_BITS 5'd16
`define CMD_MSB 15
`define CMD_LSB 12
`define CMD_BITS 4
`define CFG_MSB 11
`define CFG_BITS 12
`define RES_BITS 14
`define CFG_RESET 12'h000
`define CFG_HW_DEFAULT 12'h800
`define CMD_WRITE_CFG 4'hA
`define CMD_FIFO_READ 4'hE
`define CMD_HW_DEFAULT 4'hF
`define CMD_POWER_DOWN 4'h8
`define CMD_TEST_RSVD 4'h9
`define CFG_TWOS_BIT 7
`define CFG_SCLK_CONV_BIT 4
`define CFG_FIFO_BIT 2
`define TWOS_FLIP 14'h2000
`define PAD_BITS 2'h0
`define CONV_CYCLES 8'd40
`define SAMPLE_CYCLES 8'd20
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// ### hdl/result_fifo.v
// parameterised result buffer, registered read data
// assumes one clock domain; flush is synchronous
`timescale 1ns/1ns
module result_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_r;
  reg [AW:0] rd_r;
  wire [AW:0] used = wr_r - rd_r;
  wire empty = (used == {(AW+1){1'b0}});
  wire pop = (~out_valid | out_ready) & ~empty;
  wire [31:0] used_w = {{(31-AW){1'b0}}, used};
  assign in_ready = (used_w != DEPTH) & ~flush;
  wire push = in_valid & in_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (flush) begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_r[AW-1:0]];
        rd_r <= rd_r + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// ### hdl/adc_serial_frame_interface.v
// serial host interface and frame control of a 14-bit sampling converter
// assumes host drives SCLK/CS_N/FS/SERIAL_DATA_IN asynchronously; CLK is much faster than SCLK
`timescale 1ns/1ns
`include "adc_serial_frame_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// [RULE_01] input frame: 4-bit command on top, 12-bit config or zeros below
// [RULE_02] output frame: 14-bit result in top bits, two low bits don't care
// [RULE_03] straight binary: low ref 0000h, half 2000h, full-1 3FFFh
// [RULE_04] twos complement: low ref 2000h, mid 0000h, full-1 1FFFh
// [RULE_05] after reset end-of-conversion output high, input register all zeros
// [RULE_06] host initialises first and discards first result after power-on
// [RULE_07] two full cycles with data-in high after power-on enter default mode
// [RULE_08] default mode loads configuration 800h
// [RULE_09] host sends A000h then a configuration write for programmed mode
// [RULE_10] cycle: command decode, then sampling and conversion, ends after conversion
// [RULE_11] chip select falling with frame sync high starts frame, clears counter
// [RULE_12] chip select high: output tri-stated, input ignored, no shifting
// [RULE_13] output MSB shown before first falling clock; input MSB caught there
// [RULE_14] host ties frame sync high in chip-select mode
// [RULE_15] frame sync low at select: rising frame sync starts frame instead
// [RULE_16] host may hold chip select low with a single converter
// [RULE_17] shift out on rising clock, capture on falling clock
// [RULE_18] counter at sixteen tri-states the serial output
// [RULE_19] output word: previous result in one-shot, FIFO top when FIFO used
// [RULE_20] conversion may be timed by host serial clock when configured
// [RULE_21] active-low start input triggers conversion; end-of-conversion output
// [RULE_22] first four clocks: command shifted in while top output bits go out
// [RULE_23] command 1010b writes low 12 bits to config and resets FIFO
// [RULE_24] command 1110b presents FIFO contents on output
// [RULE_25] command 1111b enters default mode, config 800h
module adc_serial_frame_interface (
  input wire CLK,
  input wire SYS_RST,
  input wire SCLK,
  input wire CS_N,
  input wire FRAME_SYNC,
  input wire SERIAL_DATA_IN,
  input wire CONVERSION_START_N,
  input wire [13:0] SAMPLE_CODE,
  input wire SAMPLE_VALID,
  output reg SERIAL_DATA_OUT,
  output reg SERIAL_DATA_OUT_OE,
  output reg EOC_INT,
  output reg [11:0] CONFIGURATION_REGISTER,
  output reg HW_DEFAULT_MODE,
  output reg SAMPLING,
  output reg CONVERTING,
  output reg FIFO_OVERFLOW,
  output reg POWER_DOWN
);
  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers: two flops, first read only by second
  reg [4:0] s1_r;
  reg [4:0] s2_r;
  reg sclk_d_r;
  reg cs_d_r;
  reg fs_d_r;
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      // host clock idles low; a high reset value would fake a falling edge
      s1_r <= 5'h0F;
      s2_r <= 5'h0F;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      fs_d_r <= 1'b1;
    end else begin
      s1_r <= {SCLK, CS_N, FRAME_SYNC, SERIAL_DATA_IN, CONVERSION_START_N};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[4];
      cs_d_r <= s2_r[3];
      fs_d_r <= s2_r[2];
    end
  end
  wire sclk_s = s2_r[4];
  wire cs_s = s2_r[3];
  wire fs_s = s2_r[2];
  wire sdi_s = s2_r[1];
  wire conversion_start_n_s = s2_r[0];
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire cs_fall = ~cs_s & cs_d_r;
  wire fs_rise = fs_s & ~fs_d_r;
  ////////////////////////////////////////////////////////////////////////////////
  // frame state
  localparam ST_IDLE = 2'b00;
  localparam ST_ARMED = 2'b01;
  localparam ST_SHIFT = 2'b10;
  localparam ST_DONE = 2'b11;
  localparam CV_IDLE = 2'b00;
  localparam CV_SAMPLE = 2'b01;
  localparam CV_CONV = 2'b10;
  function is_select;
    input [3:0] c;
    begin
      is_select = (c[3] == 1'b0) | (c == 4'hB) | (c == 4'hC) | (c == 4'hD);
    end
  endfunction
  function [13:0] fmt_code;
    input [13:0] raw;
    input twos;
    begin
      fmt_code = twos ? (raw ^ `TWOS_FLIP) : raw; // [RULE_03] [RULE_04]
    end
  endfunction
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [4:0] bitcnt_r;
  reg [15:0] in_r;
  reg [15:0] out_r;
  reg [3:0] cmd_r;
  reg [1:0] boot_r;
  reg [13:0] last_r;
  reg [1:0] cv_r;
  reg [7:0] cvcnt_r;
  reg conversion_start_n_d_r;
  reg pop_r;
  wire f_valid;
  wire [13:0] f_data;
  wire f_in_ready;
  wire use_fifo = CONFIGURATION_REGISTER[`CFG_FIFO_BIT];
  wire [13:0] word_src = (use_fifo & f_valid) ? f_data : last_r; // [RULE_19]
  wire start = ((st_r == ST_IDLE) & cs_fall & fs_s) | (((st_r == ST_ARMED) | (st_r == ST_DONE)) & fs_rise); // [RULE_11] [RULE_15]
  wire [15:0] in_shift = {in_r[14:0], sdi_s};
  wire last_bit = (st_r == ST_SHIFT) & sclk_fall & (bitcnt_r == `FRAME_BITS - 5'd1);
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (cs_fall) begin
          st_nxt = fs_s ? ST_SHIFT : ST_ARMED; // [RULE_15]
        end
      end
      ST_ARMED: begin
        if (fs_rise) begin
          st_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (last_bit) begin
          st_nxt = ST_DONE; // [RULE_18]
        end
      end
      ST_DONE: begin
        if (fs_rise) begin
          st_nxt = ST_SHIFT;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (cs_s) begin
      st_nxt = ST_IDLE; // [RULE_12]
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // serial shifter and command decode
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r <= ST_IDLE;
      bitcnt_r <= 5'h00;
      in_r <= 16'h0000; // [RULE_05]
      out_r <= 16'h0000;
      cmd_r <= 4'h0;
      boot_r <= 2'h0;
      CONFIGURATION_REGISTER <= `CFG_RESET;
      HW_DEFAULT_MODE <= 1'b0;
      POWER_DOWN <= 1'b0;
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OUT_OE <= 1'b0;
      pop_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pop_r <= 1'b0;
      if (cs_s) begin
        SERIAL_DATA_OUT_OE <= 1'b0; // [RULE_12]
      end else if (start) begin
        bitcnt_r <= 5'h00; // [RULE_11]
        out_r <= {word_src, `PAD_BITS}; // [RULE_02]
        SERIAL_DATA_OUT <= word_src[13]; // [RULE_13]
        SERIAL_DATA_OUT_OE <= 1'b1;
        pop_r <= use_fifo & f_valid;
      end else if (st_r == ST_SHIFT) begin
        if (sclk_fall) begin
          in_r <= in_shift; // [RULE_17]
          bitcnt_r <= bitcnt_r + 5'd1;
          if (bitcnt_r == 5'd3) begin
            cmd_r <= in_shift[3:0]; // [RULE_22] [RULE_01]
            if (in_shift[3:0] == `CMD_POWER_DOWN) begin
              POWER_DOWN <= 1'b1;
            end else if (in_shift[3:0] != `CMD_TEST_RSVD) begin
              POWER_DOWN <= 1'b0;
            end
          end
          if (last_bit) begin
            SERIAL_DATA_OUT_OE <= 1'b0; // [RULE_18]
            if (in_shift[`CMD_MSB:`CMD_LSB] == `CMD_WRITE_CFG) begin
              CONFIGURATION_REGISTER <= in_shift[`CFG_MSB:0]; // [RULE_23]
              HW_DEFAULT_MODE <= 1'b0;
            end else if (in_shift[`CMD_MSB:`CMD_LSB] == `CMD_HW_DEFAULT) begin
              CONFIGURATION_REGISTER <= `CFG_HW_DEFAULT; // [RULE_25] [RULE_08]
              if (boot_r == 2'h1 || boot_r == 2'h2) begin
                HW_DEFAULT_MODE <= 1'b1; // [RULE_07]
              end
              HW_DEFAULT_MODE <= (boot_r != 2'h0) | HW_DEFAULT_MODE;
            end
            if (boot_r != 2'h2) begin
              boot_r <= (in_shift == 16'hFFFF) ? boot_r + 2'h1 : 2'h2; // [RULE_07]
            end
          end
        end else if (sclk_rise && bitcnt_r != 5'h00) begin
          out_r <= {out_r[14:0], 1'b0};
          SERIAL_DATA_OUT <= out_r[14]; // [RULE_17]
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // sampling / conversion sequencer, crude model of the analog timing
  wire twos = CONFIGURATION_REGISTER[`CFG_TWOS_BIT];
  wire sclk_conv = CONFIGURATION_REGISTER[`CFG_SCLK_CONV_BIT];
  wire conv_tick = sclk_conv ? sclk_rise : 1'b1; // [RULE_20]
  wire cmd_start = last_bit & is_select(cmd_r); // [RULE_10]
  wire hw_start = ~conversion_start_n_s & conversion_start_n_d_r; // [RULE_21]
  wire res_push = (cv_r == CV_CONV) & conv_tick & (cvcnt_r == 8'd0);
  wire flush = last_bit & (cmd_r == `CMD_WRITE_CFG); // [RULE_23]
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cv_r <= CV_IDLE;
      cvcnt_r <= 8'h00;
      conversion_start_n_d_r <= 1'b1;
      EOC_INT <= 1'b1; // [RULE_05]
      SAMPLING <= 1'b0;
      CONVERTING <= 1'b0;
      last_r <= 14'h0000;
      FIFO_OVERFLOW <= 1'b0;
    end else begin
      conversion_start_n_d_r <= conversion_start_n_s;
      // clear first so a same-cycle overflow still sets the flag
      if (flush) begin
        FIFO_OVERFLOW <= 1'b0;
      end
      case (cv_r)
        CV_IDLE: begin
          if (cmd_start | hw_start) begin
            cv_r <= CV_SAMPLE;
            cvcnt_r <= `SAMPLE_CYCLES;
            SAMPLING <= 1'b1;
            EOC_INT <= 1'b0;
          end
        end
        CV_SAMPLE: begin
          if (cvcnt_r != 8'd0) begin
            cvcnt_r <= cvcnt_r - 8'd1;
          end else if (conversion_start_n_s) begin
            cv_r <= CV_CONV; // extended sampling holds while start is low
            cvcnt_r <= `CONV_CYCLES;
            SAMPLING <= 1'b0;
            CONVERTING <= 1'b1;
          end
        end
        CV_CONV: begin
          if (conv_tick) begin
            if (cvcnt_r != 8'd0) begin
              cvcnt_r <= cvcnt_r - 8'd1;
            end else begin
              cv_r <= CV_IDLE; // [RULE_10]
              CONVERTING <= 1'b0;
              EOC_INT <= 1'b1; // [RULE_21]
              if (SAMPLE_VALID) begin
                last_r <= fmt_code(SAMPLE_CODE, twos);
              end
              if (use_fifo & ~f_in_ready) begin
                FIFO_OVERFLOW <= 1'b1;
              end
            end
          end
        end
        default: begin
          cv_r <= CV_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // result FIFO, back-pressure shows as overflow flag when the host never reads
  result_fifo #(
    .WIDTH(`RES_BITS),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .rst(SYS_RST),
    .flush(flush),
    .in_valid(res_push & use_fifo & SAMPLE_VALID),
    .in_ready(f_in_ready),
    .in_data(fmt_code(SAMPLE_CODE, twos)),
    .out_valid(f_valid),
    .out_ready(pop_r), // [RULE_24]
    .out_data(f_data)
  );
endmodule

// ### dv/adc_serial_frame_interface_props.sv
// timing checks on the ports of the serial frame interface
// assumes one CLK domain, SYS_RST async active high, bound by the bind below
`timescale 1ns/1ns
module adc_serial_frame_interface_props (
  input wire CLK,
  input wire SYS_RST,
  input wire CS_N,
  input wire SERIAL_DATA_OUT_OE,
  input wire EOC_INT,
  input wire [11:0] CONFIGURATION_REGISTER,
  input wire HW_DEFAULT_MODE,
  input wire SAMPLING,
  input wire CONVERTING
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_state: assert property ($fell(SYS_RST) |-> EOC_INT && CONFIGURATION_REGISTER == 12'h000)
    else $error("state after reset wrong");
  // five samples of select high covers the pin synchroniser
  a_oe_deselect: assert property (CS_N [*5] |-> !SERIAL_DATA_OUT_OE)
    else $error("output driven while deselected");
  a_oe_selected: assert property ($rose(SERIAL_DATA_OUT_OE) |-> !CS_N && !$past(CS_N, 2))
    else $error("output enabled without select");
  a_busy_eoc_low: assert property (SAMPLING && $past(SAMPLING, 2) |-> !EOC_INT)
    else $error("end-of-conversion high while busy");
  a_conv_follows: assert property ($fell(SAMPLING) |-> ##[0:1] CONVERTING)
    else $error("no conversion after sampling");
  a_sample_length: assert property ($rose(SAMPLING) |-> ##[18:22] !SAMPLING)
    else $error("sampling period length wrong");
  // oscillator-timed only; a host-clocked conversion stalls with the link
  a_conv_length: assert property ($rose(CONVERTING) && !CONFIGURATION_REGISTER[4] |-> CONVERTING [*8] ##[30:34] !CONVERTING)
    else $error("conversion period length wrong");
  a_cfg_in_frame: assert property ($changed(CONFIGURATION_REGISTER) |-> !CS_N)
    else $error("configuration changed while deselected");
  a_hw_cfg_load: assert property ($rose(HW_DEFAULT_MODE) |-> ##[0:2] CONFIGURATION_REGISTER == 12'h800)
    else $error("default mode without 800h");
  c_hw_mode: cover property ($rose(HW_DEFAULT_MODE));
  c_convert: cover property ($rose(CONVERTING));
  c_frame_end: cover property ($fell(SERIAL_DATA_OUT_OE) && !CS_N);
endmodule
bind adc_serial_frame_interface adc_serial_frame_interface_props u_props (.CLK(CLK), .SYS_RST(SYS_RST),
  .CS_N(CS_N), .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE), .EOC_INT(EOC_INT),
  .CONFIGURATION_REGISTER(CONFIGURATION_REGISTER), .HW_DEFAULT_MODE(HW_DEFAULT_MODE),
  .SAMPLING(SAMPLING), .CONVERTING(CONVERTING));

// ### dv/adc_host_model.sv
// host serial port model: select-started, sync-started and deselected frames
// assumes CLK is 20 ns; link clock half period is four CLK cycles
`timescale 1ns/1ns
module adc_host_model (
  input wire CLK,
  input wire SDO_LINE,
  output reg SCLK,
  output reg CS_N,
  output reg FRAME_SYNC,
  output reg SERIAL_DATA_IN
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    FRAME_SYNC = 1'b1;
    SERIAL_DATA_IN = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task wait_clk(input integer n);
    repeat (n) @(posedge CLK);
  endtask
  // mode 0 select starts, 1 frame sync starts, 2 select held high
  task xfer(input [1:0] mode, input [15:0] word, output [15:0] rx);
    integer i;
    begin
      FRAME_SYNC <= (mode != 2'd1); // held high unless sync-started
      wait_clk(4);
      CS_N <= (mode == 2'd2); // addresses this converter except in mode 2
      wait_clk(4);
      if (mode == 2'd1) begin
        FRAME_SYNC <= 1'b1;
        wait_clk(8);
        FRAME_SYNC <= 1'b0;
      end
      for (i = 15; i >= 0; i = i - 1) begin
        // data moves with the rise, never in the step of the fall
        SERIAL_DATA_IN <= word[i]; // msb first, command on top
        SCLK <= 1'b1;
        wait_clk(3);
        @(negedge CLK);
        rx[i] = SDO_LINE; // taken just before the fall
        @(posedge CLK);
        SCLK <= 1'b0;
        wait_clk(4);
      end
      wait_clk(4);
      CS_N <= 1'b1;
      SERIAL_DATA_IN <= ~word[0]; // released line never keeps its last value
      FRAME_SYNC <= 1'b1;
      wait_clk(4);
    end
  endtask
endmodule

// ### dv/adc_serial_frame_interface_tb_top.sv
// self-checking bench for the serial frame interface
// assumes the host model drives the link; analog result given on SAMPLE_CODE
`timescale 1ns/1ns
module adc_serial_frame_interface_tb_top;
  localparam [41:0] CODES = {14'h3FFF, 14'h2000, 14'h0000};
  localparam [41:0] CODES_TWOS = {14'h1FFF, 14'h0000, 14'h2000};
  reg CLK, SYS_RST, SAMPLE_VALID, CONVERSION_START_N, idle_toggle, seen_low;
  reg [13:0] SAMPLE_CODE, code;
  reg [15:0] rx;
  integer n_mismatch, checks, cycles, i, k;
  wire SCLK, CS_N, FRAME_SYNC, SERIAL_DATA_IN, SERIAL_DATA_OUT, SERIAL_DATA_OUT_OE, EOC_INT;
  wire HW_DEFAULT_MODE, SAMPLING, CONVERTING, FIFO_OVERFLOW, POWER_DOWN;
  wire [11:0] CONFIGURATION_REGISTER;
  // floating output toggles so a stale bit cannot pass
  wire sdo_line = SERIAL_DATA_OUT_OE ? SERIAL_DATA_OUT : idle_toggle;
  adc_serial_frame_interface u_adc_serial_frame_interface (.CLK(CLK), .SYS_RST(SYS_RST), .SCLK(SCLK),
    .CS_N(CS_N), .FRAME_SYNC(FRAME_SYNC), .SERIAL_DATA_IN(SERIAL_DATA_IN),
    .CONVERSION_START_N(CONVERSION_START_N), .SAMPLE_CODE(SAMPLE_CODE), .SAMPLE_VALID(SAMPLE_VALID),
    .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE), .EOC_INT(EOC_INT),
    .CONFIGURATION_REGISTER(CONFIGURATION_REGISTER), .HW_DEFAULT_MODE(HW_DEFAULT_MODE),
    .SAMPLING(SAMPLING), .CONVERTING(CONVERTING), .FIFO_OVERFLOW(FIFO_OVERFLOW), .POWER_DOWN(POWER_DOWN));
  adc_host_model u_adc_host_model (.CLK(CLK), .SDO_LINE(sdo_line), .SCLK(SCLK), .CS_N(CS_N),
    .FRAME_SYNC(FRAME_SYNC), .SERIAL_DATA_IN(SERIAL_DATA_IN));
  ////////////////////////////////////////////////////////////////////////////////
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    idle_toggle <= ~idle_toggle;
    if (EOC_INT === 1'b0) seen_low <= 1'b1;
    cycles = cycles + 1;
    if (cycles == 30000) begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task frame(input [1:0] mode, input [15:0] word);
    u_adc_host_model.xfer(mode, word, rx);
  endtask
  // bounded wait for end-of-conversion back high
  task wait_done;
    integer n;
    begin
      n = 0;
      while ((EOC_INT !== 1'b1 || n < 10) && n < 400) begin
        @(posedge CLK);
        n = n + 1;
      end
      check({15'h0, EOC_INT}, 16'h0001);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    SYS_RST = 1'b1;
    SAMPLE_CODE = 14'h0000;
    SAMPLE_VALID = 1'b1;
    CONVERSION_START_N = 1'b1; // idle high; pulsed to fill the buffer
    idle_toggle = 1'b0;
    seen_low = 1'b0;
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (4) @(posedge CLK);
    check({3'h0, EOC_INT, CONFIGURATION_REGISTER}, 16'h1000);
    check({15'h0, SERIAL_DATA_OUT_OE}, 16'h0000);
    frame(2'd0, 16'hFFFF);
    frame(2'd0, 16'hFFFF);
    wait_done;
    check({4'h0, CONFIGURATION_REGISTER}, 16'h0800);
    check({15'h0, HW_DEFAULT_MODE}, 16'h0001);
    frame(2'd2, 16'hA0FF);
    check({4'h0, CONFIGURATION_REGISTER}, 16'h0800);
    frame(2'd0, 16'hA000);
    frame(2'd1, 16'hA080);
    check({4'h0, CONFIGURATION_REGISTER}, 16'h0080);
    // both formats; first result after each start is thrown away
    for (k = 0; k < 2; k = k + 1) begin
      frame(2'd0, k ? 16'hA080 : 16'hA000);
      for (i = 0; i < 3; i = i + 1) begin
        code = CODES[i*14 +: 14];
        SAMPLE_CODE <= code;
        seen_low = 1'b0;
        frame({1'b0, i[0]}, 16'h0000);
        wait_done;
        check({15'h0, seen_low}, 16'h0001);
        frame(2'd0, 16'h0000);
        wait_done;
        check({2'b00, rx[15:2]}, {2'b00, k ? CODES_TWOS[i*14 +: 14] : code});
      end
    end
    // host clock times the conversion; it stalls while the link is idle
    frame(2'd0, 16'hA010);
    frame(2'd0, 16'h0000);
    repeat (150) @(posedge CLK);
    check({15'h0, CONVERTING}, 16'h0001);
    for (i = 0; i < 3; i = i + 1) begin
      frame(2'd0, 16'hE000);
    end
    check({14'h0, CONVERTING, EOC_INT}, 16'h0001);
    // hardware start fills the buffer: every link frame would pop its head
    frame(2'd0, 16'hA004);
    for (i = 0; i < 18; i = i + 1) begin
      SAMPLE_CODE <= 14'h0100 + i[13:0];
      CONVERSION_START_N <= 1'b0;
      repeat (4) @(posedge CLK);
      CONVERSION_START_N <= 1'b1;
      wait_done;
    end
    check({15'h0, FIFO_OVERFLOW}, 16'h0001);
    for (i = 0; i < 16; i = i + 1) begin
      frame(2'd0, 16'hE000);
      check({2'b00, rx[15:2]}, 16'h0100 + i[15:0]);
    end
    frame(2'd0, 16'h8000);
    check({15'h0, POWER_DOWN}, 16'h0001);
    frame(2'd0, 16'hA000);
    check({15'h0, FIFO_OVERFLOW}, 16'h0000);
    check({15'h0, POWER_DOWN}, 16'h0000);
    final_report;
  end
endmodule
